// >>> src/floppy_host_status_tape_regs.sv
// apb register block: drive output, tape assignment and controller status
`timescale 1ns/100ps

module floppy_host_status_tape_regs (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] read_lanes_driven,
    input wire logic [3:0] drive_seek_active,
    input wire logic cmd_first_byte,
    input wire logic cmd_last_byte,
    input wire logic cmd_has_result,
    input wire logic result_phase_end,
    input wire logic exec_phase_active,
    input wire logic polled_mode_sel,
    input wire logic host_transfer_request,
    input wire logic transfer_direction,
    output logic drive_sel_low_first,
    output logic drive_sel_low_second,
    output logic motor_low_first,
    output logic motor_low_second,
    output logic motor_out_first,
    output logic motor_out_second,
    output logic motor_out_third,
    output logic motor_out_3,
    output logic [3:0] drive_select_onehot,
    output logic ctrl_reset_n,
    output logic dma_enable
);

    logic [7:0] drive_output_reg_r;
    logic [1:0] tape_select_field_r;
    logic [7:0] drive_type_config_r;
    logic [1:0] boot_drive_config_r;
    logic enhanced_mode_r;
    logic cmd_busy_r;
    logic [31:0] prdata_r;
    logic [7:0] lanes_r;

    logic setup_phase;
    logic access_phase;
    logic word_aligned;
    logic [5:0] reg_index;
    logic hit_dout;
    logic hit_tape;
    logic hit_status;
    logic hit_type;
    logic hit_boot;
    logic hit_mode;
    logic mapped;
    logic wr_en;
    logic [7:0] wbyte;
    logic [1:0] sel_code;
    logic [1:0] selected_type;
    logic [7:0] tape_read;
    logic [7:0] status_read;
    logic [7:0] read_byte;
    logic [7:0] read_lanes;

    // ---------------- apb decode ----------------
    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign word_aligned = (paddr[1:0] == 2'h0);
    assign reg_index = paddr[7:2];
    assign hit_dout = word_aligned && (reg_index == fdc_regs_pkg::IDX_DRIVE_OUTPUT);
    assign hit_tape = word_aligned && (reg_index == fdc_regs_pkg::IDX_TAPE_ASSIGN);
    assign hit_status = word_aligned && (reg_index == fdc_regs_pkg::IDX_CONTROLLER_STATUS);
    assign hit_type = word_aligned && (reg_index == fdc_regs_pkg::IDX_DRIVE_TYPE_CFG);
    assign hit_boot = word_aligned && (reg_index == fdc_regs_pkg::IDX_BOOT_DRIVE_CFG);
    assign hit_mode = word_aligned && (reg_index == fdc_regs_pkg::IDX_FLOPPY_MODE);
    assign mapped = hit_dout || hit_tape || hit_status || hit_type || hit_boot || hit_mode;

    // zero wait states; reads are prepared in the setup cycle
    assign pready = 1'b1;
    // a write to the read-only status register is refused like an unmapped access
    assign pslverr = access_phase && (!mapped || (pwrite && hit_status));
    // only the low byte lane carries register data
    assign wr_en = access_phase && pwrite && mapped && pstrb[0];
    assign wbyte = pwdata[7:0];

    // ---------------- drive output register ----------------
    // not touched by the controller's own soft reset, only by rstn
    always_ff @(posedge clk) begin
        if (!rstn) begin
            drive_output_reg_r <= fdc_regs_pkg::DOUT_RESET;
        end else if (wr_en && hit_dout) begin
            drive_output_reg_r <= wbyte;
        end
    end

    assign sel_code = drive_output_reg_r[fdc_regs_pkg::DOUT_SEL_LSB +: 2];

    // pin outputs registered from the stored value: they follow a write by one cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            drive_sel_low_first <= 1'b1;
            drive_sel_low_second <= 1'b1;
            motor_low_first <= 1'b1;
            motor_low_second <= 1'b1;
            motor_out_first <= 1'b0;
            motor_out_second <= 1'b0;
            motor_out_third <= 1'b0;
            motor_out_3 <= 1'b0;
            drive_select_onehot <= 4'h0;
            ctrl_reset_n <= 1'b0;
            dma_enable <= 1'b0;
        end else begin
            // a select only goes low when its motor bit is set too
            drive_sel_low_first <= !((sel_code == 2'h0) && drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR0]);
            drive_sel_low_second <= !((sel_code == 2'h1) && drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR1]);
            motor_low_first <= !drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR0];
            motor_low_second <= !drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR1];
            motor_out_first <= drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR0];
            motor_out_second <= drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR1];
            motor_out_third <= drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR2];
            motor_out_3 <= drive_output_reg_r[fdc_regs_pkg::DOUT_MOTOR3];
            drive_select_onehot <= 4'h1 << sel_code;
            ctrl_reset_n <= drive_output_reg_r[fdc_regs_pkg::DOUT_SOFT_RESET_N];
            dma_enable <= drive_output_reg_r[fdc_regs_pkg::DOUT_DMA_EN];
        end
    end

    // ---------------- tape assignment ----------------
    // only rstn clears it; the soft reset bit never reaches here
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tape_select_field_r <= fdc_regs_pkg::TAPE_SEL_RESET;
        end else if (wr_en && hit_tape) begin
            // upper bits are read-only or reserved and drop writes
            tape_select_field_r <= wbyte[fdc_regs_pkg::TAPE_SEL_LSB +: 2];
        end
    end
    // code 00 means no tape drive, so drive 0 can never be chosen

    // ---------------- configuration ----------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            drive_type_config_r <= fdc_regs_pkg::DRIVE_TYPE_RESET;
        end else if (wr_en && hit_type) begin
            drive_type_config_r <= wbyte;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            boot_drive_config_r <= fdc_regs_pkg::BOOT_DRIVE_RESET;
        end else if (wr_en && hit_boot) begin
            boot_drive_config_r <= wbyte[1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            enhanced_mode_r <= fdc_regs_pkg::MODE_RESET;
        end else if (wr_en && hit_mode) begin
            enhanced_mode_r <= wbyte[fdc_regs_pkg::MODE_ENHANCED];
        end
    end

    // ---------------- command busy ----------------
    // set wins when a new command starts in the cycle the old one ends
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cmd_busy_r <= 1'b0;
        end else if (cmd_first_byte) begin
            cmd_busy_r <= 1'b1;
        end else if (result_phase_end) begin
            cmd_busy_r <= 1'b0;
        end else if (cmd_last_byte && !cmd_has_result) begin
            cmd_busy_r <= 1'b0;
        end
    end

    // ---------------- read path ----------------
    assign selected_type = drive_type_config_r[{sel_code, 1'b0} +: 2];

    always_comb begin
        tape_read = 8'h00;
        tape_read[fdc_regs_pkg::TAPE_SEL_LSB +: 2] = tape_select_field_r;
        if (enhanced_mode_r) begin
            tape_read[fdc_regs_pkg::TAPE_TYPE_LSB +: 2] = selected_type;
            tape_read[fdc_regs_pkg::TAPE_BOOT_LSB +: 2] = boot_drive_config_r;
        end
    end

    // live inputs, so a read right after a data transfer sees fresh status
    always_comb begin
        status_read = 8'h00;
        status_read[fdc_regs_pkg::STAT_SEEK_LSB +: 4] = drive_seek_active;
        status_read[fdc_regs_pkg::STAT_CMD_BUSY] = cmd_busy_r | cmd_first_byte;
        status_read[fdc_regs_pkg::STAT_NON_DMA] = polled_mode_sel && exec_phase_active;
        status_read[fdc_regs_pkg::STAT_DIRECTION] = transfer_direction;
        status_read[fdc_regs_pkg::STAT_REQUEST] = host_transfer_request;
    end

    always_comb begin
        read_byte = 8'h00;
        read_lanes = fdc_regs_pkg::LANES_ALL;
        if (hit_dout) begin
            read_byte = drive_output_reg_r;
        end else if (hit_tape) begin
            read_byte = tape_read;
            if (!enhanced_mode_r) begin
                read_lanes = fdc_regs_pkg::LANES_NORMAL_TAPE;
            end
        end else if (hit_status) begin
            read_byte = status_read;
        end else if (hit_type) begin
            read_byte = drive_type_config_r;
        end else if (hit_boot) begin
            read_byte = {6'h00, boot_drive_config_r};
        end else if (hit_mode) begin
            read_byte = {7'h00, enhanced_mode_r};
        end
    end

    // read data captured in the setup cycle; reads change no state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            prdata_r <= 32'h0000_0000;
            lanes_r <= fdc_regs_pkg::LANES_ALL;
        end else if (setup_phase && !pwrite) begin
            prdata_r <= {24'h00_0000, read_byte};
            lanes_r <= read_lanes;
        end
    end

    assign prdata = prdata_r;
    assign read_lanes_driven = lanes_r;

endmodule

// >>> src/fdc_regs_pkg.sv
// register map, field positions and reset values of the floppy host register block
//
// Behaviour
// - drive output bit 7 drives fourth motor
// - two-drive decode gated by code and motor bit
// - low motor outputs invert bits 5 and 4
// - tape register offset 3, two-bit select
// - drive 0 never gets tape support
// - tape register survives software reset
// - normal mode drives only tape bits 1:0
// - enhanced mode bits 7:6 read zero, ignore writes
// - enhanced bits 5:4 give selected drive type
// - enhanced bits 3:2 give boot drive config
// - status register read-only at offset 4, harmless
// - status reflects changes with no delay
// - status bits 3:0 show drive seeking
// - bit 4 set on first byte, clears after results
// - no-result commands clear bit 4 after last byte
// - bit 5 shows polled execution phase
// - bit 6 gives transfer direction
// - bit 7 allows data byte transfer
// - drive output bits 1:0 select one drive
// - drive output bits 4..6 drive motors 0..2
package fdc_regs_pkg;

    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_DRIVE_OUTPUT = 6'h02;
    localparam logic [5:0] IDX_TAPE_ASSIGN = 6'h03;
    localparam logic [5:0] IDX_CONTROLLER_STATUS = 6'h04;
    localparam logic [5:0] IDX_DRIVE_TYPE_CFG = 6'h10;
    localparam logic [5:0] IDX_BOOT_DRIVE_CFG = 6'h11;
    localparam logic [5:0] IDX_FLOPPY_MODE = 6'h12;

    // drive output register fields
    localparam int DOUT_SEL_LSB = 0;
    localparam int DOUT_SOFT_RESET_N = 2;
    localparam int DOUT_DMA_EN = 3;
    localparam int DOUT_MOTOR0 = 4;
    localparam int DOUT_MOTOR1 = 5;
    localparam int DOUT_MOTOR2 = 6;
    localparam int DOUT_MOTOR3 = 7;

    // tape register fields in enhanced mode 2
    localparam int TAPE_SEL_LSB = 0;
    localparam int TAPE_BOOT_LSB = 2;
    localparam int TAPE_TYPE_LSB = 4;

    // mode register field: 1 selects enhanced mode 2
    localparam int MODE_ENHANCED = 0;

    // status register fields
    localparam int STAT_SEEK_LSB = 0;
    localparam int STAT_CMD_BUSY = 4;
    localparam int STAT_NON_DMA = 5;
    localparam int STAT_DIRECTION = 6;
    localparam int STAT_REQUEST = 7;

    // values after hardware reset
    localparam logic [7:0] DOUT_RESET = 8'h00;
    localparam logic [1:0] TAPE_SEL_RESET = 2'h0;
    localparam logic [7:0] DRIVE_TYPE_RESET = 8'h00;
    localparam logic [1:0] BOOT_DRIVE_RESET = 2'h0;
    localparam logic MODE_RESET = 1'b0;

    // lanes driven on a tape register read in normal mode
    localparam logic [7:0] LANES_NORMAL_TAPE = 8'h03;
    localparam logic [7:0] LANES_ALL = 8'hff;

    // host values that spin up drives 0..3 with dma on and reset released
    localparam logic [7:0] DOUT_SPIN_DRIVE0 = 8'h1c;
    localparam logic [7:0] DOUT_SPIN_DRIVE1 = 8'h2d;
    localparam logic [7:0] DOUT_SPIN_DRIVE2 = 8'h4e;
    localparam logic [7:0] DOUT_SPIN_DRIVE3 = 8'h8f;

endpackage

// >>> bench/fdc_regs_assertions.sv
// assertions on the ports of the floppy register block
`timescale 1ns/100ps
module fdc_regs_assertions (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [3:0] drive_seek_active,
    input wire logic cmd_first_byte,
    input wire logic cmd_last_byte,
    input wire logic cmd_has_result,
    input wire logic exec_phase_active,
    input wire logic polled_mode_sel,
    input wire logic host_transfer_request,
    input wire logic transfer_direction,
    input wire logic drive_sel_low_first,
    input wire logic drive_sel_low_second,
    input wire logic motor_low_first,
    input wire logic motor_low_second,
    input wire logic motor_out_first,
    input wire logic motor_out_second,
    input wire logic motor_out_3,
    input wire logic [3:0] drive_select_onehot
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // bit 4 is left out here: the busy assertions below own it
    logic [7:0] live_status;
    assign live_status = {host_transfer_request, transfer_direction, exec_phase_active && polled_mode_sel, 1'b0,
        drive_seek_active};
    sequence s_st_setup;
        psel && !penable && !pwrite && paddr == 8'h10;
    endsequence
    sequence s_dout_wr;
        psel && penable && pwrite && pstrb[0] && paddr == 8'h08;
    endsequence
    a_motor_fourth: assert property (s_dout_wr |-> ##2 motor_out_3 == $past(pwdata[7], 2))
        else $error("fourth motor output does not follow the written bit");
    a_motor_inverse: assert property (
        motor_low_first == !motor_out_first && motor_low_second == !motor_out_second)
        else $error("low motor outputs are not the inverse of the motor bits");
    a_sel_first: assert property (drive_sel_low_first == !(drive_select_onehot[0] && motor_out_first))
        else $error("first drive select decode wrong");
    a_sel_second: assert property (drive_sel_low_second == !(drive_select_onehot[1] && motor_out_second))
        else $error("second drive select decode wrong");
    a_one_select: assert property ($past(rstn) |-> $onehot(drive_select_onehot))
        else $error("drive select is not one-hot");
    a_status_live: assert property (
        s_st_setup |=> (prdata[7:0] & 8'hef) == $past(live_status))
        else $error("status read does not show the live inputs");
    a_busy_set: assert property (s_st_setup ##0 cmd_first_byte |=> prdata[4])
        else $error("command busy not set on first byte");
    a_busy_drop: assert property (
        $past(cmd_last_byte && !cmd_has_result && !cmd_first_byte) && !cmd_first_byte ##0 s_st_setup |=> !prdata[4])
        else $error("command busy still set after last byte");
    a_status_ro: assert property (psel && penable && pwrite && paddr == 8'h10 |-> pslverr)
        else $error("write to status register not refused");
endmodule
bind floppy_host_status_tape_regs fdc_regs_assertions i_fdc_regs_assertions (.clk, .rstn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pstrb, .prdata, .pslverr, .drive_seek_active, .cmd_first_byte, .cmd_last_byte, .cmd_has_result,
    .exec_phase_active, .polled_mode_sel, .host_transfer_request, .transfer_direction, .drive_sel_low_first,
    .drive_sel_low_second, .motor_low_first, .motor_low_second, .motor_out_first, .motor_out_second, .motor_out_3,
    .drive_select_onehot);

// >>> bench/fdc_seq_model.sv
// command sequencer stand-in: first byte, last byte, optional result end
`timescale 1ns/100ps
module fdc_seq_model (
    input wire logic clk,
    input wire logic go,
    input wire logic with_result,
    output logic cmd_first_byte,
    output logic cmd_last_byte,
    output logic cmd_has_result,
    output logic result_phase_end,
    output logic [4:0] step
);
    logic [4:0] cnt = 5'h00;
    always @(posedge clk) begin
        if (go)
            cnt <= 5'h01;
        else if (cnt == 5'h14)
            cnt <= 5'h00;
        else if (cnt != 5'h00)
            cnt <= cnt + 5'h01;
    end
    // phases spaced apart so the host has room to poll between them
    assign step = cnt;
    assign cmd_first_byte = cnt == 5'h01;
    assign cmd_last_byte = cnt == 5'h08;
    assign cmd_has_result = with_result;
    assign result_phase_end = with_result && cnt == 5'h10;
endmodule

// >>> bench/floppy_host_status_tape_regs_tb.sv
// self-checking bench of the floppy register block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module floppy_host_status_tape_regs_tb;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, with_result = 1'b0;
    logic exec_phase_active = 1'b0, polled_mode_sel = 1'b0, host_transfer_request = 1'b0, transfer_direction = 1'b0;
    logic [7:0] paddr = 8'h00, rv, read_lanes_driven;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic [3:0] pstrb = 4'h1, drive_seek_active = 4'h0, drive_select_onehot;
    logic pready, pslverr, ev, cmd_first_byte, cmd_last_byte, cmd_has_result, result_phase_end, ctrl_reset_n;
    logic drive_sel_low_first, drive_sel_low_second, motor_low_first, motor_low_second, dma_enable;
    logic motor_out_first, motor_out_second, motor_out_third, motor_out_3;
    logic [4:0] step;
    logic [7:0] spin [5] = '{8'h1c, 8'h2d, 8'h4e, 8'h8f, 8'h32};
    int error_cnt = 0, n_tests = 0;
    floppy_host_status_tape_regs i_floppy_host_status_tape_regs (.clk, .rstn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .read_lanes_driven, .drive_seek_active, .cmd_first_byte,
        .cmd_last_byte, .cmd_has_result, .result_phase_end, .exec_phase_active, .polled_mode_sel,
        .host_transfer_request, .transfer_direction, .drive_sel_low_first, .drive_sel_low_second, .motor_low_first,
        .motor_low_second, .motor_out_first, .motor_out_second, .motor_out_third, .motor_out_3,
        .drive_select_onehot, .ctrl_reset_n, .dma_enable);
    fdc_seq_model i_fdc_seq_model (.clk, .go, .with_result, .cmd_first_byte, .cmd_last_byte, .cmd_has_result,
        .result_phase_end, .step);
    initial forever #2 clk = ~clk;
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // one apb transfer; a released bus gets one idle edge before the next setup
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h00_0000, d};
        psel <= 1'b1;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata[7:0];
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // no limit of its own: the watchdog ends a wait that never comes
    task automatic wt(input logic [4:0] s);
        do @(negedge clk); while (step !== s);
        @(posedge clk);
    endtask
    task automatic cmd(input logic res);
        with_result <= res;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        acc(8'h10, 1'b0, 8'h00);
        `CHK("busy_first", 1'b1, rv[4])
        wt(5'h08);
        acc(8'h10, 1'b0, 8'h00);
        `CHK("busy_last", res, rv[4])
        wt(5'h13);
        acc(8'h10, 1'b0, 8'h00);
        `CHK("busy_end", 1'b0, rv[4])
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        logic [7:0] d;
        logic [1:0] sl;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        acc(8'h0c, 1'b0, 8'h00);
        `CHK("tape_rst", 8'h00, rv)
        `CHK("tape_lanes", 8'h03, read_lanes_driven)
        acc(8'h0c, 1'b1, 8'hff);
        acc(8'h0c, 1'b0, 8'h00);
        `CHK("tape_norm", 8'h03, rv)
        $display("test tape_normal done");
        for (int i = 0; i < 5; i++) begin
            d = spin[i];
            acc(8'h08, 1'b1, d);
            @(posedge clk);
            `CHK("motor3", d[7], motor_out_3)
            `CHK("motor_low", ~d[5:4], {motor_low_second, motor_low_first})
            `CHK("motor_hi", d[6:4], {motor_out_third, motor_out_second, motor_out_first})
            `CHK("onehot", 4'h1 << d[1:0], drive_select_onehot)
            `CHK("ctl_dma", d[3:2], {dma_enable, ctrl_reset_n})
            sl = {!(d[1:0] == 2'h1 && d[5]), !(d[1:0] == 2'h0 && d[4])};
            `CHK("sel_low", sl, {drive_sel_low_second, drive_sel_low_first})
        end
        $display("test drive_output done");
        acc(8'h0c, 1'b1, 8'h02);
        acc(8'h08, 1'b1, 8'h00);
        acc(8'h0c, 1'b0, 8'h00);
        `CHK("tape_soft", 8'h02, rv)
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        acc(8'h0c, 1'b0, 8'h00);
        `CHK("tape_hard", 8'h00, rv)
        $display("test resets done");
        acc(8'h48, 1'b1, 8'h01);
        acc(8'h40, 1'b1, 8'he4);
        acc(8'h44, 1'b1, 8'h02);
        for (int c = 0; c < 4; c++) begin
            acc(8'h0c, 1'b1, {6'h3f, c[1:0]});
            acc(8'h08, 1'b1, {6'h00, c[1:0]});
            acc(8'h0c, 1'b0, 8'h00);
            `CHK("tape_enh", {2'h0, c[1:0], 2'h2, c[1:0]}, rv)
        end
        `CHK("lanes_enh", 8'hff, read_lanes_driven)
        $display("test tape_enhanced done");
        drive_seek_active <= 4'h5;
        exec_phase_active <= 1'b1;
        polled_mode_sel <= 1'b1;
        host_transfer_request <= 1'b1;
        transfer_direction <= 1'b1;
        acc(8'h10, 1'b0, 8'h00);
        `CHK("status_a", 8'he5, rv)
        acc(8'h10, 1'b1, 8'h00);
        `CHK("status_err", 1'b1, ev)
        drive_seek_active <= 4'ha;
        polled_mode_sel <= 1'b0;
        transfer_direction <= 1'b0;
        acc(8'h10, 1'b0, 8'h00);
        `CHK("status_b", 8'h8a, rv)
        cmd(1'b0);
        cmd(1'b1);
        $display("test status done");
        test_done();
    end
endmodule
